// [actr_pkg.sv]
// Function
// R1: Slope code top bits at 0x50 bits 3:2
// R2: Slope code low bits at 0x59 bits 7:5
// R3: Slope code fixed, never changes in operation
// R4: Host derives slope as 365 plus code uV
// R5: Zero code read back as two's-complement byte
// R6: Host scales zero code at 1 mV/count
// R7: Host back-calculates protection thresholds from trims
// R8: Writes to trim registers are ignored
package actr_pkg;

  // Register pointers on the serial port
  localparam logic [7:0] ADDR_SLOPE_HI = 8'h50;
  localparam logic [7:0] ADDR_ZERO = 8'h51;
  localparam logic [7:0] ADDR_SLOPE_LO = 8'h59;

  // Field positions
  localparam int SLOPE_HI_LSB = 2;
  localparam int SLOPE_LO_LSB = 5;
  localparam int SLOPE_W = 5;
  localparam int SLOPE_LO_W = 3;

  // Reset values and byte length of the port logic
  localparam logic [7:0] PTR_RST = 8'h00;
  localparam logic [3:0] BIT_CNT_RST = 4'h0;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // Serial port states
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_AACK, ST_PTR, ST_PACK,
    ST_WDAT, ST_WACK, ST_RDAT, ST_MACK
  } actr_state_e;

endpackage : actr_pkg

// [actr_trim_regs.sv]
`timescale 1ns/1ps
module actr_trim_regs
  import actr_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h08, // Arbitrary bus address
  parameter logic [4:0] SLOPE_TRIM = 5'h00, // Production trim
  parameter logic [7:0] ZERO_TRIM = 8'h00 // Production trim
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Serial clock from the host
  input wire logic scl_in,
  // Open-drain data line
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_prev_q;
  logic sda_prev_q;
  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  actr_state_e state_q, state_d;
  logic [3:0] cnt_q, cnt_d;
  logic [7:0] shreg_q, shreg_d;
  logic [7:0] ptr_q, ptr_d;
  logic rd_q, rd_d;
  logic nack_q, nack_d;
  logic oe_q, oe_d;
  logic [4:0] slope_q;
  logic [7:0] zero_q;
  logic [7:0] rd_word;

  // Map a pointer to the byte the host sees; unmapped bytes read zero
  function automatic logic [7:0] reg_read(input logic [7:0] ptr,
                                          input logic [4:0] slope,
                                          input logic [7:0] zero);
    logic [7:0] v;
    v = 8'h00;
    case (ptr)
      // R1: upper slope bits
      ADDR_SLOPE_HI: v[SLOPE_HI_LSB +: 2] = slope[SLOPE_W-1 -: 2];
      // R5: zero code passed as raw signed byte
      ADDR_ZERO: v = zero;
      // R2: lower slope bits
      ADDR_SLOPE_LO: v[SLOPE_LO_LSB +: SLOPE_LO_W] = slope[SLOPE_LO_W-1:0];
      default: v = 8'h00;
    endcase
    return v;
  endfunction : reg_read

  // R3: trims load constants and never take a new value
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      slope_q <= SLOPE_TRIM;
      zero_q <= ZERO_TRIM;
    end else begin
      slope_q <= slope_q;
      zero_q <= zero_q;
    end
  end

  // Pins cross in through two flops; edges judged on the second only
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else begin
      scl_sync_q <= {scl_sync_q[0], scl_in};
      sda_sync_q <= {sda_sync_q[0], sda_in};
      scl_prev_q <= scl_sync_q[1];
      sda_prev_q <= sda_sync_q[1];
    end
  end

  // Bus events
  assign scl_rise = scl_sync_q[1] & ~scl_prev_q;
  assign scl_fall = ~scl_sync_q[1] & scl_prev_q;
  assign start_cond = scl_sync_q[1] & scl_prev_q & sda_prev_q & ~sda_sync_q[1];
  assign stop_cond = scl_sync_q[1] & scl_prev_q & ~sda_prev_q & sda_sync_q[1];
  assign rd_word = reg_read(ptr_q, slope_q, zero_q);

  // Line only ever pulled low; release is the enable dropping
  assign sda_out = 1'b0;
  assign sda_oe = oe_q;

  // Serial port sequencing; SDA changes only after SCL falls
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    shreg_d = shreg_q;
    ptr_d = ptr_q;
    rd_d = rd_q;
    nack_d = nack_q;
    oe_d = oe_q;
    if (start_cond) begin
      state_d = ST_ADDR;
      cnt_d = BIT_CNT_RST;
      oe_d = 1'b0;
    end else if (stop_cond) begin
      state_d = ST_IDLE;
      oe_d = 1'b0;
    end else if (scl_rise) begin
      case (state_q)
        ST_ADDR, ST_PTR, ST_WDAT: begin
          shreg_d = {shreg_q[6:0], sda_sync_q[1]};
          cnt_d = cnt_q + 4'h1;
        end
        ST_RDAT: cnt_d = cnt_q + 4'h1;
        ST_MACK: nack_d = sda_sync_q[1];
        default: cnt_d = cnt_q;
      endcase
    end else if (scl_fall) begin
      case (state_q)
        ST_ADDR: begin
          if (cnt_q == BITS_PER_BYTE) begin
            // Foreign addresses are left alone until the next start
            if (shreg_q[7:1] == DEV_ADDR) begin
              state_d = ST_AACK;
              rd_d = shreg_q[0];
              oe_d = 1'b1;
            end else begin
              state_d = ST_IDLE;
            end
          end
        end
        ST_AACK: begin
          cnt_d = BIT_CNT_RST;
          if (rd_q) begin
            state_d = ST_RDAT;
            shreg_d = rd_word;
            oe_d = ~rd_word[7];
          end else begin
            state_d = ST_PTR;
            oe_d = 1'b0;
          end
        end
        ST_PTR: begin
          if (cnt_q == BITS_PER_BYTE) begin
            ptr_d = shreg_q;
            state_d = ST_PACK;
            oe_d = 1'b1;
          end
        end
        ST_WDAT: begin
          // R8: data byte acknowledged but dropped
          if (cnt_q == BITS_PER_BYTE) begin
            state_d = ST_WACK;
            oe_d = 1'b1;
          end
        end
        ST_PACK, ST_WACK: begin
          state_d = ST_WDAT;
          cnt_d = BIT_CNT_RST;
          oe_d = 1'b0;
        end
        ST_RDAT: begin
          if (cnt_q == BITS_PER_BYTE) begin
            state_d = ST_MACK;
            ptr_d = ptr_q + 8'h01; // Auto-increment for burst reads
            oe_d = 1'b0;
          end else begin
            shreg_d = {shreg_q[6:0], 1'b0};
            oe_d = ~shreg_q[6];
          end
        end
        ST_MACK: begin
          if (!nack_q) begin
            state_d = ST_RDAT;
            cnt_d = BIT_CNT_RST;
            shreg_d = rd_word;
            oe_d = ~rd_word[7];
          end else begin
            state_d = ST_IDLE;
          end
        end
        default: state_d = ST_IDLE;
      endcase
    end
  end

  // Port state registers
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= ST_IDLE;
      cnt_q <= BIT_CNT_RST;
      shreg_q <= 8'h00;
      ptr_q <= PTR_RST;
      rd_q <= 1'b0;
      nack_q <= 1'b1;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      shreg_q <= shreg_d;
      ptr_q <= ptr_d;
      rd_q <= rd_d;
      nack_q <= nack_d;
      oe_q <= oe_d;
    end
  end

  // Checks on what the host will be shown
  property p_slope_hi;
    @(posedge clk) disable iff (sys_rst)
      (state_q == ST_AACK && rd_q && scl_fall && ptr_q == ADDR_SLOPE_HI)
      |=> (shreg_q[3:2] == slope_q[4:3] && shreg_q[7:4] == 4'h0
           && shreg_q[1:0] == 2'b00);
  endproperty
  a_slope_hi: assert property (p_slope_hi) // R1
    else $error("upper slope bits misplaced");

  property p_slope_lo;
    @(posedge clk) disable iff (sys_rst)
      (state_q == ST_AACK && rd_q && scl_fall && ptr_q == ADDR_SLOPE_LO)
      |=> (shreg_q[7:5] == slope_q[2:0] && shreg_q[4:0] == 5'h00
           && sda_oe == ~slope_q[2]);
  endproperty
  a_slope_lo: assert property (p_slope_lo) // R2
    else $error("lower slope bits misplaced");

  property p_slope_fixed;
    @(posedge clk) disable iff (sys_rst)
      $stable(slope_q) && slope_q == SLOPE_TRIM;
  endproperty
  a_slope_fixed: assert property (p_slope_fixed) // R3
    else $error("slope trim changed");

  property p_zero_raw;
    @(posedge clk) disable iff (sys_rst)
      (state_q == ST_AACK && rd_q && scl_fall && ptr_q == ADDR_ZERO)
      |=> (shreg_q == zero_q && sda_oe == ~zero_q[7]);
  endproperty
  a_zero_raw: assert property (p_zero_raw) // R5
    else $error("zero code not returned as raw byte");

  property p_write_ignored;
    @(posedge clk) disable iff (sys_rst)
      (state_q == ST_WDAT && state_d == ST_WACK)
      |=> (slope_q == SLOPE_TRIM && zero_q == ZERO_TRIM
           && $stable(ptr_q) && oe_q);
  endproperty
  a_write_ignored: assert property (p_write_ignored) // R8
    else $error("write disturbed trim contents");

endmodule : actr_trim_regs

// [actr_host.sv]
`timescale 1ns/1ps
module actr_host
  import actr_pkg::*;
#(
  parameter logic [6:0] DEV = 7'h08 // Arbitrary, matches device
) (
  // Clock
  input wire logic clk,
  // Bus lines, data is open drain
  output logic scl,
  output logic sda_low,
  input wire logic sda
);
  int nak = 0;
  // Idle bus: clock high, data released
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end
  // Quarter cell of 8 clk, well above the device sync need
  task q;
    repeat (8) @(negedge clk);
  endtask : q
  // One bit cell, sample while the clock is high
  task bit_io(input logic b, output logic r);
    sda_low = !b;
    q;
    scl = 1'h1;
    q;
    r = sda;
    q;
    scl = 1'h0;
    q;
  endtask : bit_io
  // Start, also usable as repeated start
  task go;
    sda_low = 1'h0;
    scl = 1'h1;
    q;
    sda_low = 1'h1;
    q;
    scl = 1'h0;
    q;
  endtask : go
  task halt;
    sda_low = 1'h1;
    q;
    scl = 1'h1;
    q;
    sda_low = 1'h0;
    q;
  endtask : halt
  // Byte MSB first, m drives the ninth bit, a samples it
  task xfer(input logic [7:0] d, input logic m, output logic [7:0] r,
            output logic a);
    for (int i = 7; i >= 0; i--) bit_io(d[i], r[i]);
    bit_io(m, a);
  endtask : xfer
  // Pointer write, then optional data byte or read
  task acc(input logic [7:0] p, input logic wr, input logic [7:0] d,
           output logic [7:0] r);
    logic [7:0] t;
    logic a;
    go;
    xfer({DEV, 1'h0}, 1'h1, t, a);
    nak += a;
    xfer(p, 1'h1, t, a);
    nak += a;
    if (wr) begin
      xfer(d, 1'h1, t, a);
      nak += a;
    end else begin
      go;
      xfer({DEV, 1'h1}, 1'h1, t, a);
      nak += a;
      xfer(8'hff, 1'h1, r, a);
    end
    halt;
  endtask : acc
  // slope in uV from the code
  function automatic int slope_uv(input logic [4:0] c);
    return 365 + c;
  endfunction : slope_uv
  function automatic int zero_mv(input logic [7:0] c);
    return $signed(c);
  endfunction : zero_mv
  // raw threshold code from a target in uV, truncating
  function automatic int raw_code(input int uv, input logic [4:0] s,
                                  input logic [7:0] z);
    return (uv - zero_mv(z) * 32'sh3e8) / slope_uv(s);
  endfunction : raw_code
endmodule : actr_host

// [test_adc_calibration_trim_readout.sv]
`timescale 1ns/1ps
module test_adc_calibration_trim_readout;
  import actr_pkg::*;
  localparam logic [4:0] S = 5'h1d;
  localparam logic [7:0] Z = 8'h80;
  localparam logic [6:0] DEV = 7'h08; // Arbitrary bus address
  typedef struct packed {logic [7:0] p; logic [7:0] e;} actr_row_s;
  // Pointer and expected byte; 0x52 is unmapped
  actr_row_s rows [4] = '{'{ADDR_SLOPE_HI, {4'h0, S[4:3], 2'h0}},
    '{ADDR_ZERO, Z}, '{ADDR_SLOPE_LO, {S[2:0], 5'h0}}, '{8'h52, 8'h00}};
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic scl, sda_low, sda_out, sda_oe, a;
  wire logic sda;
  logic [7:0] r, t, got [4];
  int n_errors = 0;
  int compares = 0;
  // Wired-AND with pull-up
  assign sda = !(sda_low || sda_oe);
  actr_trim_regs #(.DEV_ADDR(DEV), .SLOPE_TRIM(S), .ZERO_TRIM(Z))
    actr_trim_regs_i (
    .clk(clk), .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe));
  actr_host #(.DEV(DEV)) actr_host_i (.clk(clk), .scl(scl),
    .sda_low(sda_low), .sda(sda));
  task chk(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask : chk
  // Full-width compare so sign and range errors are not cut away
  task chk_w(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %0t got %h want %h", $time, g, e);
    end
  endtask : chk_w
  task close_out;
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  // Clock, 50 ns period
  initial begin
    forever #25 clk = !clk;
  end
  // Main sequence
  initial begin
    repeat (4) @(negedge clk);
    chk({6'h0, sda_oe, sda_out}, 8'h00);
    sys_rst = 1'h0;
    repeat (4) @(negedge clk);
    for (int i = 0; i < 4; i++) begin
      actr_host_i.acc(rows[i].p, 1'h0, 8'h00, got[i]);
      chk(got[i], rows[i].e);
    end
    chk_w(actr_host_i.slope_uv({got[0][3:2], got[2][7:5]}), 32'h0000018a);
    chk_w(actr_host_i.zero_mv(got[1]), 32'hffffff80);
    // 4.3 V target: (4300000 + 128000) / 394 truncates to 11238
    chk_w(actr_host_i.raw_code(32'h00419ce0, {got[0][3:2], got[2][7:5]},
      got[1]), 32'h00002be6);
    // Writes to both trim registers are dropped; read back shows the original trims
    actr_host_i.acc(ADDR_SLOPE_HI, 1'h1, 8'hff, t);
    actr_host_i.acc(ADDR_ZERO, 1'h1, 8'h7f, t);
    actr_host_i.acc(ADDR_SLOPE_HI, 1'h0, 8'h00, r);
    chk(r, rows[0].e);
    actr_host_i.acc(ADDR_ZERO, 1'h0, 8'h00, r);
    chk(r, Z);
    // Burst read: pointer steps after each byte; host acknowledge fetches the next register
    actr_host_i.go;
    actr_host_i.xfer({DEV, 1'h0}, 1'h1, t, a);
    actr_host_i.xfer(ADDR_SLOPE_HI, 1'h1, t, a);
    actr_host_i.go;
    actr_host_i.xfer({DEV, 1'h1}, 1'h1, t, a);
    actr_host_i.xfer(8'hff, 1'h0, got[0], a);
    actr_host_i.xfer(8'hff, 1'h1, got[1], a);
    actr_host_i.halt;
    chk(got[0], rows[0].e);
    chk(got[1], Z);
    // Foreign address must not be acknowledged
    actr_host_i.go;
    actr_host_i.xfer(8'h12, 1'h1, t, a);
    chk({7'h0, a}, 8'h01);
    actr_host_i.halt;
    // Mid-run reset leaves the trims as they were
    sys_rst = 1'h1;
    repeat (2) @(negedge clk);
    chk({7'h0, sda_oe}, 8'h00);
    sys_rst = 1'h0;
    repeat (4) @(negedge clk);
    actr_host_i.acc(ADDR_SLOPE_LO, 1'h0, 8'h00, r);
    chk(r, rows[2].e);
    chk(8'(actr_host_i.nak), 8'h00);
    close_out;
  end
endmodule : test_adc_calibration_trim_readout
